// File: core/configurable_io_ports.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "gpio_ports_params.svh"
module configurable_io_ports
    import gpio_ports_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] portBIn,
    input wire logic [7:0] portGIn,
    input wire logic [7:0] portLIn,
    output pad_drive_type portBPad,
    output pad_drive_type portGPad,
    output pad_drive_type portLPad,
    input wire logic [7:0] optionByte,
    input wire logic supervisionIn,
    input wire logic oscClkIn,
    input wire logic [7:0] analogSelect,
    output logic haltRequest,
    output logic idleRequest,
    output logic serialAltPhase,
    output logic supervisionEnabled,
    output logic [5:0] analogChannels,
    output g_alt_type gAlt,
    output l_alt_type lAlt
);
    port_regs_type portB;
    port_regs_type portG;
    port_regs_type portL;
    port_regs_type next_portB;
    port_regs_type next_portG;
    port_regs_type next_portL;
    port_bits_type pinB;
    port_bits_type pinG;
    port_bits_type pinL;
    logic addrTake;
    logic wrPending;
    logic [`REG_ADDR_BITS-1:0] wrAddr;
    logic haltHit;
    logic idleHit;
    logic optionTaken;
    port_bits_type gOvrMask;
    port_bits_type gOvrOut;
    port_bits_type gOvrOe;
    port_bits_type gOvrPull;
    port_bits_type bHizMask;

    // one readback function so that every read path decodes alike
    function automatic logic [31:0] readReg(
        input logic [`REG_ADDR_BITS-1:0] addr,
        input port_regs_type b,
        input port_regs_type g,
        input port_regs_type l,
        input port_bits_type pb,
        input port_bits_type pg,
        input port_bits_type pl,
        input port_bits_type analog
    );
        logic [31:0] value;
        value = `AHB_DATA_ZERO;
        case (addr)
            `REG_B_CFG: value[7:0] = b.cfg;
            `REG_B_LATCH: value[7:0] = b.latch;
            // unbonded and analog bits are undefined; they read as zero here
            `REG_B_PIN: value[7:0] = pb & `B_BONDED_MASK & ~analog;
            `REG_G_CFG: value[7:0] = g.cfg;
            `REG_G_LATCH: value[7:0] = g.latch & `G_LATCH_KEEP_MASK;
            `REG_G_PIN: value[7:0] = pg;
            `REG_L_CFG: value[7:0] = l.cfg;
            `REG_L_LATCH: value[7:0] = l.latch;
            `REG_L_PIN: value[7:0] = pl;
            default: value = `AHB_DATA_ZERO;
        endcase
        return value;
    endfunction

    ahb_write_capture #(
        .ADDR_BITS(`REG_ADDR_BITS)
    ) busFront (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .addrTake(addrTake),
        .wrPending(wrPending),
        .wrAddr(wrAddr)
    );

    // write data arrive in the data phase; pin registers have no write case
    always_comb begin
        next_portB = portB;
        next_portG = portG;
        next_portL = portL;
        haltHit = 1'b0;
        idleHit = 1'b0;
        if (wrPending) begin
            case (wrAddr)
                `REG_B_CFG: next_portB.cfg = hwdata[7:0];
                `REG_B_LATCH: next_portB.latch = hwdata[7:0];
                `REG_G_CFG: next_portG.cfg = hwdata[7:0] & `G_CFG_KEEP_MASK;
                `REG_G_LATCH: begin
                    next_portG.latch = hwdata[7:0] & `G_LATCH_KEEP_MASK;
                    haltHit = hwdata[`G_HALT_BIT];
                    idleHit = hwdata[`G_IDLE_BIT];
                end
                `REG_L_CFG: next_portL.cfg = hwdata[7:0];
                `REG_L_LATCH: next_portL.latch = hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            portB <= '{cfg: `PORT_RESET, latch: `PORT_RESET};
            portG <= '{cfg: `PORT_RESET, latch: `PORT_RESET};
            portL <= '{cfg: `PORT_RESET, latch: `PORT_RESET};
        end else begin
            portB <= next_portB;
            portG <= next_portG;
            portL <= next_portL;
        end
    end

    // low-power requests are one-cycle pulses, not stored state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            haltRequest <= 1'b0;
            idleRequest <= 1'b0;
        end else begin
            haltRequest <= haltHit;
            idleRequest <= idleHit;
        end
    end

    assign serialAltPhase = portG.cfg[`G_ALT_PHASE_BIT];

    // pads are taken as synchronous, so one stage is enough
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pinB <= `PORT_RESET;
            pinG <= `PORT_RESET;
            pinL <= `PORT_RESET;
        end else begin
            pinB <= portBIn;
            pinG <= portGIn;
            pinL <= portLIn;
        end
    end

    // option byte is caught once at the first edge after reset release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            optionTaken <= 1'b0;
            supervisionEnabled <= 1'b0;
        end else if (!optionTaken) begin
            optionTaken <= 1'b1;
            supervisionEnabled <= optionByte[`OPT_SUPERVISION_BIT];
        end
    end

    // read data are sampled in the address phase, forwarding a write in flight
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= `AHB_DATA_ZERO;
            hreadyout <= 1'b1;
            hresp <= `AHB_RESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `AHB_RESP_OKAY;
            if (addrTake && !hwrite) begin
                hrdata <= readReg(haddr[`REG_ADDR_BITS-1:0], next_portB, next_portG,
                                  next_portL, pinB, pinG, pinL, analogSelect);
            end
        end
    end

    // supervision output pulls up when high and pulls the pin down when low
    always_comb begin
        gOvrMask = `G_CLOCK_OUT_MASK;
        gOvrOut = `PORT_RESET;
        gOvrOe = `G_CLOCK_OUT_MASK;
        gOvrPull = `PORT_RESET;
        gOvrOut[`G_CLOCK_OUT_BIT] = oscClkIn;
        if (supervisionEnabled) begin
            gOvrMask = gOvrMask | `G_SUPERVISION_MASK;
            gOvrOe[`G_SUPERVISION_BIT] = !supervisionIn;
            gOvrPull[`G_SUPERVISION_BIT] = supervisionIn;
        end
    end

    // analog pins and unbonded pads are never driven by the digital cell
    assign bHizMask = ~`B_BONDED_MASK | analogSelect;

    pin_drive_bank #(
        .WIDTH(`PORT_WIDTH)
    ) bankB (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .cfg(portB.cfg),
        .latch(portB.latch),
        .hizMask(bHizMask),
        .ovrMask(`PORT_RESET),
        .ovrOut(`PORT_RESET),
        .ovrOe(`PORT_RESET),
        .ovrPull(`PORT_RESET),
        .padOut(portBPad.out),
        .padOe(portBPad.oe),
        .padPull(portBPad.pull)
    );

    pin_drive_bank #(
        .WIDTH(`PORT_WIDTH)
    ) bankG (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .cfg(portG.cfg),
        .latch(portG.latch),
        .hizMask(`G_INPUT_ONLY_MASK),
        .ovrMask(gOvrMask),
        .ovrOut(gOvrOut),
        .ovrOe(gOvrOe),
        .ovrPull(gOvrPull),
        .padOut(portGPad.out),
        .padOe(portGPad.oe),
        .padPull(portGPad.pull)
    );

    pin_drive_bank #(
        .WIDTH(`PORT_WIDTH)
    ) bankL (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .cfg(portL.cfg),
        .latch(portL.latch),
        .hizMask(`PORT_RESET),
        .ovrMask(`PORT_RESET),
        .ovrOut(`PORT_RESET),
        .ovrOe(`PORT_RESET),
        .ovrPull(`PORT_RESET),
        .padOut(portLPad.out),
        .padOe(portLPad.oe),
        .padPull(portLPad.pull)
    );

    // peripherals see the sampled pad levels of their alternate pins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gAlt <= '0;
            lAlt <= '0;
            analogChannels <= '0;
        end else begin
            gAlt.serialDataIn <= portGIn[6];
            gAlt.serialShiftClock <= portGIn[5];
            gAlt.serialDataOut <= portGIn[4];
            gAlt.timer1IoPin <= portGIn[3];
            gAlt.timer1CapturePin <= portGIn[2];
            gAlt.externalInterruptPin <= portGIn[0];
            lAlt.wakeupLevels <= portLIn;
            lAlt.timer3InputPin <= portLIn[7];
            lAlt.timer3IoPin <= portLIn[6];
            lAlt.timer2InputPin <= portLIn[5];
            lAlt.timer2IoPin <= portLIn[4];
            lAlt.serialPortReceive <= portLIn[3];
            lAlt.serialPortTransmit <= portLIn[2];
            lAlt.serialPortClock <= portLIn[1];
            // channel 10 is bit 2 up to channel 15 on bit 7
            analogChannels <= analogSelect[`B_ANALOG_MSB:`B_ANALOG_LSB];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence gLatchWrite;
        wrPending && wrAddr == `REG_G_LATCH;
    endsequence

    sequence gLatchRead;
        addrTake && !hwrite && haddr[`REG_ADDR_BITS-1:0] == `REG_G_LATCH;
    endsequence

    sequence pinLWrite;
        wrPending && wrAddr == `REG_L_PIN;
    endsequence

    pull_mode_a: assert property (##1 portLPad.pull == $past(~portL.cfg & portL.latch))
        else $error("port L pull-up does not follow config and latch");

    drive_mode_a: assert property (##1 portLPad.oe == $past(portL.cfg)
        && (portLPad.out & portLPad.oe) == $past(portL.cfg & portL.latch))
        else $error("port L drive does not follow config and latch");

    g6_hiz_a: assert property (!portGPad.oe[6] && !portGPad.pull[6])
        else $error("port G pin 6 is not a hi-z input");

    // the edge that releases reset still resets the pads, so start one edge later
    clock_out_a: assert property (resetn |=> portGPad.oe[7]
        && portGPad.out[7] == $past(oscClkIn))
        else $error("port G pin 7 does not carry the clock");

    supervision_pin_a: assert property (supervisionEnabled && !supervisionIn
        |=> !$past(supervisionEnabled) || (portGPad.oe[1] && !portGPad.out[1]))
        else $error("supervision output does not pull pin 1 low");

    halt_pulse_a: assert property (gLatchWrite ##0 hwdata[`G_HALT_BIT] |=> haltRequest)
        else $error("halt write gave no halt request");

    halt_cause_a: assert property (haltRequest |-> $past(wrPending && wrAddr == `REG_G_LATCH
        && hwdata[`G_HALT_BIT]))
        else $error("halt request without a halt write");

    idle_pulse_a: assert property (gLatchWrite ##0 hwdata[`G_IDLE_BIT] |=> idleRequest
        && !haltRequest == !$past(hwdata[`G_HALT_BIT]))
        else $error("idle write gave no idle request");

    latch_top_a: assert property (gLatchRead |=> hrdata[7:6] == 2'b00)
        else $error("port G latch bits 6 and 7 read nonzero");

    alt_phase_a: assert property (wrPending && wrAddr == `REG_G_CFG
        |=> serialAltPhase == $past(hwdata[`G_ALT_PHASE_BIT]) && !portG.cfg[7])
        else $error("alternate phase bit not taken from config write");

    pin_level_a: assert property (pinLWrite |=> pinL == $past(portLIn)
        && portL == $past(portL))
        else $error("pin register write had an effect");

    bus_okay_a: assert property (hreadyout && hresp == `AHB_RESP_OKAY)
        else $error("slave stalled or answered with an error");

    unbonded_hiz_a: assert property (((portBPad.oe | portBPad.pull)
        & ~`B_BONDED_MASK) == `PORT_RESET)
        else $error("unbonded port B pad is driven or pulled");

    analog_hiz_a: assert property (resetn |=> ((portBPad.oe | portBPad.pull)
        & $past(analogSelect)) == `PORT_RESET)
        else $error("analog port B pin is driven or pulled");

    option_hold_a: assert property (optionTaken |=> $stable(supervisionEnabled))
        else $error("supervision option changed after capture");
endmodule

// File: pkg/gpio_ports_params.svh
`ifndef GPIO_PORTS_PARAMS_SVH
`define GPIO_PORTS_PARAMS_SVH

`define PORT_WIDTH 8
`define PORT_RESET 8'h00
`define PORT_ALL_ON 8'hFF

`define REG_B_CFG 8'h00
`define REG_B_LATCH 8'h04
`define REG_B_PIN 8'h08
`define REG_G_CFG 8'h10
`define REG_G_LATCH 8'h14
`define REG_G_PIN 8'h18
`define REG_L_CFG 8'h20
`define REG_L_LATCH 8'h24
`define REG_L_PIN 8'h28
`define REG_ADDR_BITS 8

`define B_BONDED_MASK 8'hFC
`define B_ANALOG_LSB 2
`define B_ANALOG_MSB 7
`define G_LATCH_KEEP_MASK 8'h3F
`define G_CFG_KEEP_MASK 8'h7F
`define G_HALT_BIT 7
`define G_IDLE_BIT 6
`define G_ALT_PHASE_BIT 6
`define G_INPUT_ONLY_MASK 8'h40
`define G_CLOCK_OUT_MASK 8'h80
`define G_SUPERVISION_MASK 8'h02
`define G_CLOCK_OUT_BIT 7
`define G_SUPERVISION_BIT 1
`define OPT_SUPERVISION_BIT 2

`define AHB_TRANS_NONSEQ 2'b10
`define AHB_RESP_OKAY 1'b0
`define AHB_DATA_ZERO 32'h00000000

`endif

// File: pkg/gpio_ports_pkg.sv
`include "gpio_ports_params.svh"
package gpio_ports_pkg;
    typedef logic [`PORT_WIDTH-1:0] port_bits_type;

    typedef struct packed {
        port_bits_type cfg;
        port_bits_type latch;
    } port_regs_type;

    typedef struct packed {
        port_bits_type out;
        port_bits_type oe;
        port_bits_type pull;
    } pad_drive_type;

    typedef struct packed {
        logic serialDataIn;
        logic serialShiftClock;
        logic serialDataOut;
        logic timer1IoPin;
        logic timer1CapturePin;
        logic externalInterruptPin;
    } g_alt_type;

    typedef struct packed {
        port_bits_type wakeupLevels;
        logic timer3InputPin;
        logic timer3IoPin;
        logic timer2InputPin;
        logic timer2IoPin;
        logic serialPortReceive;
        logic serialPortTransmit;
        logic serialPortClock;
    } l_alt_type;
endpackage

// File: core/pin_drive_bank.sv
`timescale 1ns/1ps
`include "gpio_ports_params.svh"
module pin_drive_bank
    import gpio_ports_pkg::*;
#(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] cfg,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] hizMask,
    input wire logic [WIDTH-1:0] ovrMask,
    input wire logic [WIDTH-1:0] ovrOut,
    input wire logic [WIDTH-1:0] ovrOe,
    input wire logic [WIDTH-1:0] ovrPull,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOe,
    output logic [WIDTH-1:0] padPull
);
    initial begin
        if (WIDTH < 1 || WIDTH > `PORT_WIDTH) begin
            $error("pin_drive_bank: WIDTH out of range");
        end
    end

    // registered so the pads never see decode glitches
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            padOut <= '0;
            padOe <= '0;
            padPull <= '0;
        end else begin
            // 00 hi-z, 01 pull-up, 10 drive low, 11 drive high
            padOut <= (ovrMask & ovrOut) | (~ovrMask & ~hizMask & latch & cfg);
            padOe <= (ovrMask & ovrOe) | (~ovrMask & ~hizMask & cfg);
            padPull <= (ovrMask & ovrPull) | (~ovrMask & ~hizMask & ~cfg & latch);
        end
    end
endmodule

// File: core/ahb_write_capture.sv
`timescale 1ns/1ps
`include "gpio_ports_params.svh"
module ahb_write_capture
    import gpio_ports_pkg::*;
#(
    parameter int ADDR_BITS = `REG_ADDR_BITS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic addrTake,
    output logic wrPending,
    output logic [ADDR_BITS-1:0] wrAddr
);
    initial begin
        if (ADDR_BITS < 6 || ADDR_BITS > 32) begin
            $error("ahb_write_capture: ADDR_BITS out of range");
        end
    end

    // only NONSEQ is used by a single-transfer master; SEQ is treated alike
    assign addrTake = hsel && hready && htrans[1];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPending <= 1'b0;
            wrAddr <= '0;
        end else begin
            wrPending <= addrTake && hwrite;
            if (addrTake) begin
                wrAddr <= haddr[ADDR_BITS-1:0];
            end
        end
    end
endmodule

// File: tb/pin_board_model.sv
`timescale 1ns/1ps
module pin_board_model
    import gpio_ports_pkg::*;
(
    input wire logic ref_clk,
    input wire pad_drive_type bPad,
    input wire pad_drive_type gPad,
    input wire pad_drive_type lPad,
    input wire logic [23:0] extOe,
    input wire logic [23:0] extVal,
    output logic [7:0] portBIn,
    output logic [7:0] portGIn,
    output logic [7:0] portLIn
);
    logic floatPhase = 1'b0;

    // an undriven pad wanders, so nothing may rely on a floating level
    always @(posedge ref_clk) begin
        floatPhase <= ~floatPhase;
    end

    function automatic port_bits_type level(input pad_drive_type p, input port_bits_type eo,
        input port_bits_type ev, input logic fl);
        port_bits_type r;
        for (int i = 0; i < 8; i++) begin
            if (p.oe[i] && eo[i]) begin
                r[i] = (p.out[i] == ev[i]) ? ev[i] : 1'bx;
            end else if (p.oe[i]) begin
                r[i] = p.out[i];
            end else if (eo[i]) begin
                r[i] = ev[i];
            end else if (p.pull[i]) begin
                r[i] = 1'b1;
            end else begin
                r[i] = fl ^ i[0];
            end
        end
        return r;
    endfunction

    assign portBIn = level(bPad, extOe[7:0], extVal[7:0], floatPhase);
    assign portGIn = level(gPad, extOe[15:8], extVal[15:8], floatPhase);
    assign portLIn = level(lPad, extOe[23:16], extVal[23:16], floatPhase);
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "gpio_ports_params.svh"
module testbench
    import gpio_ports_pkg::*;
;
    logic ref_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] portBIn, portGIn, portLIn, optionByte, analogSelect;
    logic supervisionIn, oscClkIn, haltRequest, idleRequest, serialAltPhase, supervisionEnabled;
    logic [5:0] analogChannels;
    pad_drive_type portBPad, portGPad, portLPad;
    g_alt_type gAlt;
    l_alt_type lAlt;
    logic [23:0] extOe, extVal;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    assign hready = hreadyout;

    configurable_io_ports configurable_io_ports_inst (.ref_clk(ref_clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .portBIn(portBIn), .portGIn(portGIn), .portLIn(portLIn),
        .portBPad(portBPad), .portGPad(portGPad), .portLPad(portLPad),
        .optionByte(optionByte), .supervisionIn(supervisionIn), .oscClkIn(oscClkIn),
        .analogSelect(analogSelect), .haltRequest(haltRequest), .idleRequest(idleRequest),
        .serialAltPhase(serialAltPhase), .supervisionEnabled(supervisionEnabled),
        .analogChannels(analogChannels), .gAlt(gAlt), .lAlt(lAlt));

    pin_board_model pin_board_model_inst (.ref_clk(ref_clk), .bPad(portBPad), .gPad(portGPad),
        .lPad(portLPad), .extOe(extOe), .extVal(extVal), .portBIn(portBIn),
        .portGIn(portGIn), .portLIn(portLIn));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // generous ceiling: the full sequence needs about 120 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            stop_test;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= `AHB_TRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'b1, {24'h000000, d}, r);
    endtask

    // upper data bits are always compared; mask hides floating pins and any others a call leaves unchecked
    task automatic rd_check(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h00000000, r);
        check(r & {24'hFFFFFF, mask}, {24'h000000, exp & mask});
    endtask

    task automatic set_port(input logic [7:0] base, input logic [7:0] c, input logic [7:0] l);
        wr(base, c);
        wr(base + 8'h04, l);
        wait_clk(2);
    endtask

    task automatic pad_check(input pad_drive_type p, input logic [7:0] oe,
        input logic [7:0] out, input logic [7:0] pull);
        check({8'h00, p.out & oe, p.oe, p.pull}, {8'h00, out & oe, oe, pull});
    endtask

    task automatic do_reset;
        resetn <= 1'b0;
        wait_clk(4);
        resetn <= 1'b1;
        wait_clk(2);
    endtask

    task automatic t_reset;
        logic [7:0] regs [6] = '{`REG_B_CFG, `REG_B_LATCH, `REG_G_CFG, `REG_G_LATCH,
            `REG_L_CFG, `REG_L_LATCH};
        foreach (regs[i]) rd_check(regs[i], 8'hFF, 8'h00);
        rd_check(8'h3C, 8'hFF, 8'h00);
        pad_check(portLPad, 8'h00, 8'h00, 8'h00);
        check({30'h0, hreadyout, hresp}, 32'h00000002);
        $display("test reset done");
    endtask

    task automatic t_modes;
        set_port(`REG_L_CFG, 8'h33, 8'h55);
        pad_check(portLPad, 8'h33, 8'h11, 8'h44);
        rd_check(`REG_L_PIN, 8'h77, 8'h55);
        rd_check(`REG_L_CFG, 8'hFF, 8'h33);
        rd_check(`REG_L_LATCH, 8'hFF, 8'h55);
        extOe <= 24'h040000;
        extVal <= 24'h000000;
        wait_clk(3);
        rd_check(`REG_L_PIN, 8'h77, 8'h51);
        extOe <= 24'h000000;
        set_port(`REG_L_CFG, 8'hCC, 8'hAA);
        pad_check(portLPad, 8'hCC, 8'h88, 8'h22);
        rd_check(`REG_L_PIN, 8'hEE, 8'hAA);
        $display("test modes done");
    endtask

    task automatic t_portb;
        analogSelect <= 8'h30;
        set_port(`REG_B_CFG, 8'hFF, 8'hFF);
        pad_check(portBPad, 8'hCC, 8'hCC, 8'h00);
        check({26'h0, analogChannels}, 32'h0000000C);
        rd_check(`REG_B_PIN, 8'hCC, 8'hCC);
        analogSelect <= 8'h00;
        set_port(`REG_B_CFG, 8'h00, 8'h00);
        $display("test port b done");
    endtask

    task automatic pulse(input logic [7:0] d, input logic [1:0] exp);
        wr(`REG_G_LATCH, d);
        #1;
        check({30'h0, haltRequest, idleRequest}, {30'h0, exp});
        @(posedge ref_clk);
        #1;
        check({30'h0, haltRequest, idleRequest}, 32'h0);
        // hand back on a rising edge so the next transfer starts there
        @(posedge ref_clk);
    endtask

    task automatic t_portg;
        oscClkIn <= 1'b1;
        set_port(`REG_G_CFG, 8'hFF, 8'h3F);
        pad_check(portGPad, 8'hBF, 8'hBF, 8'h00);
        check({31'h0, serialAltPhase}, 32'h1);
        rd_check(`REG_G_CFG, 8'hFF, 8'h7F);
        oscClkIn <= 1'b0;
        wait_clk(2);
        pad_check(portGPad, 8'hBF, 8'h3F, 8'h00);
        pulse(8'hFF, 2'b11);
        rd_check(`REG_G_LATCH, 8'hFF, 8'h3F);
        pulse(8'h80, 2'b10);
        pulse(8'h40, 2'b01);
        set_port(`REG_G_CFG, 8'h00, 8'h00);
        check({31'h0, serialAltPhase}, 32'h0);
        $display("test port g done");
    endtask

    task automatic t_alt;
        set_port(`REG_L_CFG, 8'h00, 8'h00);
        extOe <= 24'hFF7F00;
        extVal <= 24'hA55A00;
        wait_clk(3);
        check({26'h0, gAlt}, 32'h0000002C);
        check({17'h0, lAlt}, {17'h0, 8'hA5, 7'b1010010});
        rd_check(`REG_G_PIN, 8'h7F, 8'h5A);
        wr(`REG_L_PIN, 8'h00);
        rd_check(`REG_L_PIN, 8'hFF, 8'hA5);
        extOe <= 24'h000000;
        $display("test alternate taps done");
    endtask

    task automatic t_superv;
        optionByte <= 8'h04;
        do_reset;
        check({31'h0, supervisionEnabled}, 32'h1);
        set_port(`REG_G_CFG, 8'h02, 8'h02);
        check({30'h0, portGPad.oe[1], portGPad.pull[1]}, 32'h1);
        supervisionIn <= 1'b0;
        wait_clk(3);
        check({29'h0, portGPad.oe[1], portGPad.out[1], portGPad.pull[1]}, 32'h4);
        $display("test supervision done");
    endtask

    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        optionByte = 8'h00;
        analogSelect = 8'h00;
        supervisionIn = 1'b1;
        oscClkIn = 1'b0;
        extOe = 24'h000000;
        extVal = 24'h000000;
        do_reset;
        t_reset;
        t_modes;
        t_portb;
        t_portg;
        t_alt;
        t_superv;
        stop_test;
    end
endmodule
